// *** sdlcfs_pkg.sv ***
// Purpose: shared constants and types for the SDLC frame controller
// Assumes: 100 MHz system clock, 8-bit control images
// Notes: residue codes other than one and two bits are local choices
`default_nettype none
package sdlcfs_pkg;
  localparam int MCLK_MHZ = 100;
  localparam int MISS_NS = 320;
  localparam int MISS_CYC = (MISS_NS * MCLK_MHZ) / 1000;
  localparam int TXC_RTS = 1;
  localparam int EXT_AUTO_RTS = 2;
  localparam int LINE_UNDER = 2;
  localparam int LINE_MARK = 3;
  localparam int LINE_ENC = 5;
  localparam int MODE_SEL = 4;
  localparam int FIFO_EN = 2;
  localparam int STAT_OVF = 7;
  localparam int STAT_VALID = 6;
  localparam int MAIN_ABORT = 7;
  localparam int CLK_MISS = 6;
  localparam int STAT_DEPTH = 10;
  localparam int TX_DEPTH = 16;
  localparam logic [1:0] ENC_NRZI = 2'h1;
  localparam logic [1:0] MODE_SDLC = 2'h2;
  localparam logic [1:0] RXI_SPECIAL = 2'h3;
  localparam logic [7:0] FLAG = 8'h7e;
  localparam logic [6:0] ABORT = 7'h7f;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_GOOD = 16'hf0b8;
  // Residue code per leftover bit count, count 0 in the low slice
  localparam logic [23:0] RES_CODES = 24'hd5423b;
  typedef enum logic [2:0] {TX_IDLE, TX_OPEN, TX_DATA, TX_CRC, TX_CLOSE}
    sdlcfs_txst_t;
  typedef struct packed {
    logic [7:0] txCtrl, extOpt, lineOpt, mode, fifoCtl;
    logic [1:0] rxIntMode;
  } sdlcfs_cfg_t;
  typedef struct packed {logic statusRead, errorReset, resetIus;} sdlcfs_cmd_t;
  typedef struct packed {
    logic [7:0] frameStatus, mainStatus, clockStatus, rxCond;
  } sdlcfs_stat_t;
  typedef struct packed {logic valid, eof; logic [7:0] data;} sdlcfs_char_t;
  typedef struct packed {
    sdlcfs_txst_t st; logic [7:0] sh; logic [3:0] cnt; logic [15:0] crc;
    logic lvl, pin, rts, und;
  } sdlcfs_txs_t;
  localparam sdlcfs_txs_t TX_RESET = '{st: TX_IDLE, sh: FLAG, cnt: 4'h0,
    crc: CRC_INIT, lvl: 1'b1, pin: 1'b1, rts: 1'b0, und: 1'b0};
  typedef struct packed {
    logic [8:0] sr; logic inFr; logic [3:0] skip; logic [2:0] rcnt;
    logic [7:0] rbyte, holdD, nbytes; logic holdV; logic [15:0] crc;
    sdlcfs_char_t tail; logic locked, rx_char_available_irq, abrt, missOnce, twoMiss;
    logic [7:0] missCnt, cond;
  } sdlcfs_rxs_t;
  typedef struct packed {logic [3:0] wp, rp, cnt; logic ovf, enPrev;}
    sdlcfs_sts_t;
endpackage
`default_nettype wire

// *** sdlcfs_station.sv ***
// Purpose: remote frame station facing the SDLC frame controller
// Assumes: one bit per 160 ns on both links
// Notes: no zero insertion on the line, so frame data is chosen flag-free
`timescale 1ns/1ps
`default_nettype none
module sdlcfs_station (
  input wire logic txData,
  input wire logic txRun,
  output logic txClk,
  output logic rxClk,
  output logic rxData
);
  logic [15:0] txHist = 16'h0000;
  logic [15:0] lastCrc;
  logic [7:0] seed;
  initial begin
    txClk = 1'b1;
    rxClk = 1'b0;
    rxData = 1'b1;
  end
  // Clock parks high when stopped, so no bit is ever cut short
  always #80 if (txRun || !txClk) txClk = ~txClk;
  always @(posedge txClk) txHist <= {txData, txHist[15:1]};
  task automatic put_bit(input logic b);
    rxData = b;
    #80 rxClk = 1'b1;
    #80 rxClk = 1'b0;
  endtask
  task automatic send_frame(input int nbits);
    logic b[$];
    logic [15:0] c;
    int run;
    for (seed = 8'h01; seed != 8'h00; seed++) begin
      b = {};
      c = sdlcfs_pkg::CRC_INIT;
      for (int i = 0; i < nbits; i++) begin
        b.push_back(seed[i % 8]);
        c = (c[0] ^ b[i]) ? (c >> 1) ^ sdlcfs_pkg::CRC_POLY : c >> 1;
      end
      c = ~c;
      for (int i = 0; i < 16; i++) b.push_back(c[i]);
      run = 0;
      foreach (b[i]) begin
        run = b[i] ? run + 1 : 0;
        if (run > 5) break;
      end
      if (run < 6) break;
    end
    lastCrc = c;
    for (int i = 0; i < 8; i++) put_bit(sdlcfs_pkg::FLAG[i]);
    foreach (b[i]) put_bit(b[i]);
    for (int i = 0; i < 8; i++) put_bit(sdlcfs_pkg::FLAG[i]);
    // Released line shows the inverse, never a stale level
    rxData = ~rxData;
  endtask
endmodule
`default_nettype wire

// *** sdlcfs_top.sv ***
// Purpose: SDLC transmit framer, receive deframer and frame status FIFO
// Assumes: link clocks and receive data are asynchronous pins
// Notes: no zero insertion; receive line is plain NRZ
// Summary of operation
// - Valid bit shows stored complete frame
// - Anti-lock end-of-frame read raises character interrupt
// - Control bit 1 low drives RTS on
// - Underrun pulse when data runs out
// - Auto RTS release after closing flag when LINE_UNDER clear
// - Auto release waits through any frame chain
// - NRZI mark idle forces line high in SDLC mode
// - Forced high never delays next frame
// - Ten entries; eleventh sets overflow
// - Overflow locks status FIFO writes
// - Anti-lock overflow clears by enable toggle
// - Otherwise status read clears overflow
// - Break/abort flag clear after reset
// - Two-clocks-missing flag clear after reset
// - Residue code reported every frame
// - CRC bytes stored intact in data
// - CRC check independent of residue
// - Anti-lock end-of-frame never locks data
// - Other modes lock until error reset
`timescale 1ns/1ps
`default_nettype none
module sdlcfs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = sdlcfs_pkg::TX_DEPTH
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic wr, rd;
  assign inReady = cnt_reg != (AW+1)'(DEPTH);
  assign outValid = cnt_reg != '0;
  assign outData = mem[rp_reg];
  always_comb begin
    wr = inValid && inReady;
    rd = outValid && outReady;
    wp_next = wp_reg;
    rp_next = rp_reg;
    if (wr) wp_next = (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
    if (rd) rp_next = (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
    cnt_next = cnt_reg + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
    end
  end
  always_ff @(posedge mclk) begin
    if (wr) mem[wp_reg] <= inData;
  end
endmodule

module sdlcfs_top #(
  parameter int TX_DEPTH = sdlcfs_pkg::TX_DEPTH,
  parameter int STAT_DEPTH = sdlcfs_pkg::STAT_DEPTH
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire sdlcfs_pkg::sdlcfs_cfg_t cfg,
  input wire sdlcfs_pkg::sdlcfs_cmd_t cmd,
  input wire logic [7:0] txWrData,
  input wire logic txWrValid,
  output logic txWrReady,
  input wire logic txClkIn,
  input wire logic rxClkIn,
  input wire logic rxDataIn,
  output logic txData,
  output logic rtsN,
  output logic txUnderrun,
  output sdlcfs_pkg::sdlcfs_char_t rxChar,
  output sdlcfs_pkg::sdlcfs_stat_t stat,
  output logic irqRca,
  output logic irqSpecial
);
  sdlcfs_pkg::sdlcfs_txs_t tx_reg, tx_next;
  sdlcfs_pkg::sdlcfs_rxs_t rx_reg, rx_next;
  sdlcfs_pkg::sdlcfs_sts_t st_reg, st_next;
  sdlcfs_pkg::sdlcfs_char_t rxChar_reg, rxChar_next, outc;
  logic [11:0] stMem [STAT_DEPTH];
  logic [11:0] stEntry;
  logic [2:0] syn1_reg, syn2_reg;
  logic [1:0] syn3_reg;
  logic [7:0] fData;
  logic [8:0] s;
  logic [2:0] res;
  logic fValid, fRd, txFall, rxRise, byteEnd, bitv, stPush, stWe, pop, ok;
  logic nrzi, forceHigh, autoRts, txBusy, antiLock, fifoEn;
  logic lastBit_reg, lastBit_next, undCause;

  function automatic logic [15:0] crcStep(input logic [15:0] c,
                                          input logic b);
    crcStep = (c >> 1) ^ ((c[0] ^ b) ? sdlcfs_pkg::CRC_POLY : 16'h0000);
  endfunction

  sdlcfs_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) txFifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .inData(txWrData),
    .inValid(txWrValid),
    .inReady(txWrReady),
    .outData(fData),
    .outValid(fValid),
    .outReady(fRd)
  );

  // Order: txClk, rxClk, rxData; third stage only for edge finding
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      syn1_reg <= '0;
      syn2_reg <= '0;
      syn3_reg <= '0;
    end else begin
      syn1_reg <= {rxDataIn, rxClkIn, txClkIn};
      syn2_reg <= syn1_reg;
      syn3_reg <= syn2_reg[1:0];
    end
  end
  assign txFall = syn3_reg[0] && !syn2_reg[0];
  assign rxRise = syn2_reg[1] && !syn3_reg[1];

  assign nrzi = cfg.lineOpt[sdlcfs_pkg::LINE_ENC +: 2] == sdlcfs_pkg::ENC_NRZI;
  assign forceHigh = nrzi && cfg.lineOpt[sdlcfs_pkg::LINE_MARK] &&
    cfg.mode[sdlcfs_pkg::MODE_SEL +: 2] == sdlcfs_pkg::MODE_SDLC;
  assign autoRts = cfg.extOpt[sdlcfs_pkg::EXT_AUTO_RTS] &&
    !cfg.lineOpt[sdlcfs_pkg::LINE_UNDER];
  // Busy until the last closing-flag bit time has ended on the pin
  assign txBusy = tx_reg.st != sdlcfs_pkg::TX_IDLE ||
    lastBit_reg;
  assign fifoEn = cfg.fifoCtl[sdlcfs_pkg::FIFO_EN];
  assign antiLock = fifoEn && cfg.rxIntMode == sdlcfs_pkg::RXI_SPECIAL;

  always_comb begin
    tx_next = tx_reg;
    lastBit_next = lastBit_reg;
    tx_next.und = 1'b0;
    fRd = 1'b0;
    bitv = 1'b1;
    byteEnd = 1'b0;
    if (!cfg.txCtrl[sdlcfs_pkg::TXC_RTS]) tx_next.rts = 1'b1;
    // Auto mode holds the driver on until the whole chain has left
    else if (!(autoRts && txBusy)) tx_next.rts = 1'b0;
    if (txFall) begin
      byteEnd = (tx_reg.st == sdlcfs_pkg::TX_CRC) ? tx_reg.cnt == 4'hf :
        tx_reg.cnt == 4'h7;
      case (tx_reg.st)
        sdlcfs_pkg::TX_IDLE: bitv = cfg.lineOpt[sdlcfs_pkg::LINE_MARK] |
          tx_reg.sh[0];
        sdlcfs_pkg::TX_CRC: bitv = ~tx_reg.crc[0];
        default: bitv = tx_reg.sh[0];
      endcase
      if (tx_reg.st == sdlcfs_pkg::TX_DATA) tx_next.crc = crcStep(tx_reg.crc, bitv);
      if (tx_reg.st == sdlcfs_pkg::TX_CRC) tx_next.crc = {1'b1, tx_reg.crc[15:1]};
      // Rotation shifts bits out; every byte end reloads the flag or the next data byte
      tx_next.sh = {tx_reg.sh[0], tx_reg.sh[7:1]};
      tx_next.cnt = tx_reg.cnt + 4'h1;
      lastBit_next = byteEnd && tx_reg.st == sdlcfs_pkg::TX_CLOSE;
      if (byteEnd) begin
        tx_next.cnt = 4'h0;
        tx_next.sh = sdlcfs_pkg::FLAG;
        case (tx_reg.st)
          sdlcfs_pkg::TX_IDLE: begin
            if (fValid) tx_next.st = sdlcfs_pkg::TX_OPEN;
          end
          sdlcfs_pkg::TX_OPEN: begin
            tx_next.st = sdlcfs_pkg::TX_DATA;
            tx_next.sh = fData;
            tx_next.crc = sdlcfs_pkg::CRC_INIT;
            fRd = 1'b1;
          end
          sdlcfs_pkg::TX_DATA: begin
            if (fValid) begin
              tx_next.sh = fData;
              fRd = 1'b1;
            end else begin
              tx_next.und = 1'b1;
              tx_next.st = cfg.lineOpt[sdlcfs_pkg::LINE_UNDER] ?
                sdlcfs_pkg::TX_CLOSE : sdlcfs_pkg::TX_CRC;
            end
          end
          sdlcfs_pkg::TX_CRC: tx_next.st = sdlcfs_pkg::TX_CLOSE;
          sdlcfs_pkg::TX_CLOSE: begin
            tx_next.st = fValid ? sdlcfs_pkg::TX_OPEN : sdlcfs_pkg::TX_IDLE;
          end
          default: tx_next.st = sdlcfs_pkg::TX_IDLE;
        endcase
      end
      // Only idle bits are forced, so a chained frame is never delayed
      if (forceHigh && tx_reg.st == sdlcfs_pkg::TX_IDLE) begin
        tx_next.pin = 1'b1;
        tx_next.lvl = 1'b1;
      end else if (nrzi) begin
        tx_next.lvl = bitv ? tx_reg.lvl : ~tx_reg.lvl;
        tx_next.pin = tx_next.lvl;
      end else begin
        tx_next.pin = bitv;
      end
    end
  end

  always_comb begin
    rx_next = rx_reg;
    outc = '0;
    s = '0;
    stPush = 1'b0;
    stEntry = '0;
    res = '0;
    ok = 1'b0;
    if (rxRise) begin
      rx_next.missCnt = 8'h00;
      rx_next.missOnce = 1'b0;
      rx_next.twoMiss = 1'b0;
      s = {rx_reg.sr[7:0], syn2_reg[2]};
      rx_next.sr = s;
      if (rx_reg.inFr && rx_reg.skip != 4'h0) begin
        rx_next.skip = rx_reg.skip - 4'h1;
      end else if (rx_reg.inFr) begin
        rx_next.crc = crcStep(rx_reg.crc, s[8]);
        rx_next.rbyte = {s[8], rx_reg.rbyte[7:1]};
        rx_next.rcnt = rx_reg.rcnt + 3'h1;
        if (rx_reg.holdV) begin
          outc = '{valid: 1'b1, eof: 1'b0, data: rx_reg.holdD};
          rx_next.holdV = 1'b0;
        end
        // Every bit, CRC bits too, is stored as data
        if (rx_reg.rcnt == 3'h7) begin
          rx_next.holdV = 1'b1;
          rx_next.holdD = rx_next.rbyte;
          rx_next.nbytes = rx_reg.nbytes + 8'h01;
        end
      end
      if (s[6:0] == sdlcfs_pkg::ABORT) begin
        rx_next.inFr = 1'b0;
        rx_next.abrt = 1'b1;
      end else if (s[7:0] == sdlcfs_pkg::FLAG) begin
        rx_next.abrt = 1'b0;
        if (rx_reg.inFr && rx_reg.skip == 4'h0) begin
          // Remainder check spans every bit, so alignment cannot matter
          ok = rx_next.crc == sdlcfs_pkg::CRC_GOOD;
          res = sdlcfs_pkg::RES_CODES[3 * rx_next.rcnt +: 3];
          stPush = 1'b1;
          stEntry = {ok, res, rx_next.nbytes};
          rx_next.cond = {1'b1, ~ok, 2'b00, res, 1'b0};
          rx_next.tail.eof = 1'b1;
          if (rx_next.rcnt == 3'h0) begin
            rx_next.tail.valid = rx_next.holdV;
            rx_next.tail.data = rx_next.holdD;
          end else begin
            rx_next.tail.valid = 1'b1;
            rx_next.tail.data = rx_next.rbyte >> (4'd8 - {1'b0, rx_next.rcnt});
          end
        end
        rx_next.inFr = 1'b1;
        rx_next.skip = 4'h8;
        rx_next.rcnt = 3'h0;
        rx_next.holdV = 1'b0;
        rx_next.nbytes = 8'h00;
        rx_next.crc = sdlcfs_pkg::CRC_INIT;
      end
    end else begin
      // End-of-frame character leaves one cycle after its tick
      if (rx_reg.tail.valid) begin
        outc = rx_reg.tail;
        rx_next.tail = '0;
      end
      if (rx_reg.missCnt == 8'(sdlcfs_pkg::MISS_CYC - 1)) begin
        rx_next.missCnt = 8'h00;
        rx_next.missOnce = 1'b1;
        if (rx_reg.missOnce) rx_next.twoMiss = 1'b1;
      end else begin
        rx_next.missCnt = rx_reg.missCnt + 8'h01;
      end
    end
    rxChar_next = outc;
    // Locked data FIFO drops arriving characters until error reset
    rxChar_next.valid = outc.valid && !rx_reg.locked;
    if (cmd.errorReset) rx_next.locked = 1'b0;
    if (cmd.resetIus) rx_next.rx_char_available_irq = 1'b0;
    if (rxChar_next.valid && outc.eof) begin
      if (antiLock) rx_next.rx_char_available_irq = 1'b1;
      else rx_next.locked = 1'b1;
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.enPrev = fifoEn;
    stWe = 1'b0;
    pop = cmd.statusRead && st_reg.cnt != 4'h0 && fifoEn;
    if (!fifoEn) begin
      st_next.wp = 4'h0;
      st_next.rp = 4'h0;
      st_next.cnt = 4'h0;
    end else begin
      if (!st_reg.enPrev) st_next.ovf = 1'b0;
      if (pop) begin
        st_next.rp = (st_reg.rp == 4'(STAT_DEPTH - 1)) ? 4'h0 : st_reg.rp + 4'h1;
        st_next.cnt = st_reg.cnt - 4'h1;
        if (!antiLock) st_next.ovf = 1'b0;
      end
      if (stPush && !st_reg.ovf) begin
        if (st_next.cnt == 4'(STAT_DEPTH)) begin
          st_next.ovf = 1'b1;
        end else begin
          stWe = 1'b1;
          st_next.wp = (st_reg.wp == 4'(STAT_DEPTH - 1)) ? 4'h0 :
            st_reg.wp + 4'h1;
          st_next.cnt = st_next.cnt + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_reg <= sdlcfs_pkg::TX_RESET;
      rx_reg <= '0;
      st_reg <= '0;
      rxChar_reg <= '0;
      lastBit_reg <= 1'b0;
    end else begin
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      st_reg <= st_next;
      rxChar_reg <= rxChar_next;
      lastBit_reg <= lastBit_next;
    end
  end
  always_ff @(posedge mclk) begin
    if (stWe) stMem[st_reg.wp] <= stEntry;
  end

  assign txData = tx_reg.pin;
  assign rtsN = !tx_reg.rts;
  assign txUnderrun = tx_reg.und;
  assign rxChar = rxChar_reg;
  assign irqRca = rx_reg.rx_char_available_irq;
  assign irqSpecial = rx_reg.locked;
  // Empty FIFO shows no count, so discarded entries never leak out
  assign stat.frameStatus = {st_reg.ovf, st_reg.cnt != 4'h0,
    (st_reg.cnt != 4'h0) ? stMem[st_reg.rp][5:0] : 6'h00};
  assign stat.mainStatus = {rx_reg.abrt, 7'h00};
  assign stat.clockStatus = {1'b0, rx_reg.twoMiss, 6'h00};
  assign stat.rxCond = rx_reg.cond;

  default clocking dcb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  rts_on_a: assert property (
    !cfg.txCtrl[sdlcfs_pkg::TXC_RTS] |=> !rtsN) else $error("RTS not on");
  rts_hold_a: assert property (
    !rtsN && autoRts && txBusy |=> !rtsN) else $error("RTS dropped early");
  assign undCause = txFall && byteEnd && !fValid &&
    tx_reg.st == sdlcfs_pkg::TX_DATA;
  underrun_a: assert property (
    txUnderrun |-> $past(undCause)) else $error("Bad underrun");
  force_high_a: assert property (
    txFall && forceHigh && tx_reg.st == sdlcfs_pkg::TX_IDLE |=> txData)
    else $error("Line not forced high");
  chain_a: assert property (
    txFall && tx_reg.st == sdlcfs_pkg::TX_CLOSE && tx_reg.cnt == 4'h7 &&
    fValid |=> tx_reg.st == sdlcfs_pkg::TX_OPEN) else $error("Chain slip");
  frame_valid_a: assert property (
    stWe |=> stat.frameStatus[sdlcfs_pkg::STAT_VALID])
    else $error("Valid frame bit missing");
  ovf_set_a: assert property (
    stPush && fifoEn && st_reg.enPrev && !st_reg.ovf && !pop &&
    st_reg.cnt == 4'(STAT_DEPTH) |=> stat.frameStatus[sdlcfs_pkg::STAT_OVF])
    else $error("Overflow not flagged");
  ovf_lock_a: assert property (
    st_reg.ovf && fifoEn && st_reg.enPrev |=> st_reg.cnt <= $past(st_reg.cnt))
    else $error("Write while locked");
  rca_eof_a: assert property (
    rxChar.valid && rxChar.eof && $past(antiLock) |-> irqRca)
    else $error("End-of-frame interrupt lost");
  special_hold_a: assert property (
    irqSpecial && !cmd.errorReset |=> irqSpecial) else $error("Lock lost");
endmodule
`default_nettype wire

// *** sdlcfs_top_tb_top.sv ***
// Purpose: self-checking bench for the SDLC frame controller
// Assumes: station model makes both link clocks, 160 ns per bit
// Notes: status FIFO scenarios run dozens of frames, so the run is long
`timescale 1ns/1ps
`default_nettype none
module sdlcfs_top_tb_top;
  logic mclk = 1'b0;
  logic resetN = 1'b0;
  sdlcfs_pkg::sdlcfs_cfg_t cfg = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 2'h0};
  sdlcfs_pkg::sdlcfs_cmd_t cmd = '0;
  logic [7:0] txWrData = 8'hc3;
  logic txWrValid = 1'b0;
  logic txRun = 1'b0;
  logic txWrReady, txClk, rxClk, rxData, txData, rtsN, txUnderrun;
  logic irqRca, irqSpecial;
  sdlcfs_pkg::sdlcfs_char_t rxChar;
  sdlcfs_pkg::sdlcfs_stat_t stat;
  logic [7:0] rxQ[$];
  int undCnt = 0;
  int n_errors = 0;
  int check_count = 0;
  int k;
  always #5 mclk = ~mclk;
  sdlcfs_top DUT (.mclk(mclk), .reset_n(resetN), .cfg(cfg), .cmd(cmd),
    .txWrData(txWrData), .txWrValid(txWrValid), .txWrReady(txWrReady),
    .txClkIn(txClk), .rxClkIn(rxClk), .rxDataIn(rxData), .txData(txData),
    .rtsN(rtsN), .txUnderrun(txUnderrun), .rxChar(rxChar), .stat(stat),
    .irqRca(irqRca), .irqSpecial(irqSpecial));
  sdlcfs_station station (.txData(txData), .txRun(txRun), .txClk(txClk),
    .rxClk(rxClk), .rxData(rxData));
  always @(posedge mclk) begin
    if (rxChar.valid === 1'b1) rxQ.push_back(rxChar.data);
    if (txUnderrun === 1'b1) undCnt <= undCnt + 1;
  end
  task automatic check(input string what, input logic [15:0] exp, got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic timed_out(input string what);
    n_errors++;
    $display("unexpected %s: expected done, seen timeout", what);
    complete_run();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic setcfg(input logic [7:0] tc, eo, lo, fc,
                        input logic [1:0] im);
    @(posedge mclk);
    cfg <= '{tc, eo, lo, 8'h20, fc, im};
  endtask
  task automatic pulse(input sdlcfs_pkg::sdlcfs_cmd_t c);
    @(posedge mclk);
    cmd <= c;
    @(posedge mclk);
    cmd <= '0;
    tick(2);
  endtask
  task automatic tx_byte();
    @(posedge mclk);
    txWrValid <= 1'b1;
    @(posedge mclk);
    txWrValid <= 1'b0;
  endtask
  task automatic wait_und(input int target);
    for (k = 0; k < 6000 && undCnt < target; k++) @(posedge mclk);
    if (k == 6000) timed_out("underrun");
  endtask
  task automatic rx_frame(input int nres);
    rxQ = {};
    station.send_frame(16 + nres);
    tick(12);
  endtask
  task automatic test_reset();
    tick(2);
    check("txData", 16'h1, txData);
    check("rtsN", 16'h1, rtsN);
    check("frame status", 16'h0, stat.frameStatus);
    check("abort flag", 16'h0, stat.mainStatus[7]);
    check("clock miss flag", 16'h0, stat.clockStatus[6]);
    $display("test_reset done");
  endtask
  task automatic test_rts();
    setcfg(8'h00, 8'h00, 8'h00, 8'h00, 2'h0);
    tick(1);
    check("rtsN on", 16'h0, rtsN);
    setcfg(8'h02, 8'h00, 8'h00, 8'h00, 2'h0);
    tick(1);
    check("rtsN off", 16'h1, rtsN);
    $display("test_rts done");
  endtask
  task automatic test_tx_chain();
    int n = 0;
    int base = undCnt;
    setcfg(8'h00, 8'h04, 8'h00, 8'h00, 2'h0);
    @(posedge mclk);
    txWrValid <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge mclk);
      if (txWrReady === 1'b1) n++;
    end
    txWrValid <= 1'b0;
    check("words accepted", 16'd16, n[15:0]);
    txRun <= 1'b1;
    for (int f = 1; f <= 3; f++) begin
      wait_und(base + f);
      if (f < 3) tx_byte();
    end
    @(posedge mclk);
    cfg.txCtrl[1] <= 1'b1;
    tick(2);
    check("rtsN held", 16'h0, rtsN);
    for (k = 0; k < 1000 && rtsN !== 1'b1; k++) @(posedge mclk);
    if (k == 1000) timed_out("rts release");
    check("line byte at release", 16'h7e, station.txHist[15:8]);
    txRun <= 1'b0;
    $display("test_tx_chain done");
  endtask
  task automatic test_nrzi_idle();
    setcfg(8'h00, 8'h00, 8'h28, 8'h00, 2'h0);
    tx_byte();
    txRun <= 1'b1;
    wait_und(undCnt + 1);
    tick(26 * 16);
    for (int i = 0; i < 8; i++) begin
      check("forced high line", 16'h1, txData);
      tick(16);
    end
    txRun <= 1'b0;
    $display("test_nrzi_idle done");
  endtask
  task automatic test_rx_antilock();
    setcfg(8'h02, 8'h00, 8'h00, 8'h04, 2'h3);
    for (int r = 0; r < 3; r++) begin
      rx_frame(r);
      check("residue", r == 0 ? 16'h3 : r == 1 ? 16'h7 : 16'h0,
            stat.rxCond[3:1]);
      check("crc error", 16'h0, stat.rxCond[6]);
      check("eof interrupt", 16'h1, irqRca);
      check("data lock", 16'h0, irqSpecial);
      check("first char", station.seed, rxQ[0]);
      if (r == 0) check("crc bytes", station.lastCrc, {rxQ[3], rxQ[2]});
      pulse('{1'b0, 1'b0, 1'b1});
      check("frame available", 16'h1, stat.frameStatus[6]);
    end
    $display("test_rx_antilock done");
  endtask
  task automatic test_overflow();
    int n = 0;
    setcfg(8'h02, 8'h00, 8'h00, 8'h00, 2'h0);
    setcfg(8'h02, 8'h00, 8'h00, 8'h04, 2'h0);
    for (int f = 1; f <= 12; f++) begin
      rx_frame(0);
      if (f == 1) check("locked", 16'h1, irqSpecial);
      if (f == 1) pulse('{1'b0, 1'b0, 1'b1});
      if (f == 1) check("locked after ius", 16'h1, irqSpecial);
      if (f == 10) check("early overflow", 16'h0, stat.frameStatus[7]);
      if (f == 11) check("overflow", 16'h1, stat.frameStatus[7]);
      pulse('{1'b0, 1'b1, 1'b0});
      if (f == 1) check("unlocked", 16'h0, irqSpecial);
    end
    pulse('{1'b1, 1'b0, 1'b0});
    check("overflow read", 16'h0, stat.frameStatus[7]);
    for (k = 0; k < 20 && stat.frameStatus[6] === 1'b1; k++) begin
      pulse('{1'b1, 1'b0, 1'b0});
      n++;
    end
    check("entries left", 16'd9, n[15:0]);
    $display("test_overflow done");
  endtask
  task automatic test_antilock_overflow();
    setcfg(8'h02, 8'h00, 8'h00, 8'h04, 2'h3);
    for (int f = 0; f < 11; f++) rx_frame(0);
    check("overflow", 16'h1, stat.frameStatus[7]);
    pulse('{1'b1, 1'b0, 1'b0});
    check("overflow kept", 16'h1, stat.frameStatus[7]);
    rx_frame(0);
    for (k = 0; k < 20 && stat.frameStatus[6] === 1'b1; k++)
      pulse('{1'b1, 1'b0, 1'b0});
    check("locked entries", 16'd9, k[15:0]);
    setcfg(8'h02, 8'h00, 8'h00, 8'h00, 2'h3);
    setcfg(8'h02, 8'h00, 8'h00, 8'h04, 2'h3);
    tick(2);
    check("status cleared", 16'h0, stat.frameStatus);
    $display("test_antilock_overflow done");
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    resetN <= 1'b1;
    test_reset();
    test_rts();
    test_tx_chain();
    test_nrzi_idle();
    test_rx_antilock();
    test_overflow();
    test_antilock_overflow();
    complete_run();
  end
endmodule
`default_nettype wire
